// file: rtl/ulms_top.sv
// Line status and modem status registers of one serial channel.
// Notes on behaviour
// - Line bit 0 is high while the receive FIFO holds a character.
// - Line bit 1 is high while an overrun error is reported.
// - Parity error and framing error each have their own line bit.
// - Line bit 4 is high while a break is seen on the receive line.
// - Line bit 5 is high when the transmit holding register is empty.
// - Line bit 6 is high only when the transmit shift register is empty.
// - Line bit 7 is high when any character in the FIFO has an error.
// - Modem bit 0 sets when clear-to-send changes.
// - Modem bit 1 sets when data-set-ready changes.
// - Modem bit 2 sets only on a rising ring indicator.
// - Modem bit 3 sets when carrier-detect changes.
// - Reading the modem status clears bits 0 to 3.
// - Modem bits 4 and 5 show clear-to-send and data-set-ready levels.
// - Modem bit 6 shows the ring indicator level.
// - Modem bit 7 shows the carrier-detect level.
// - In loopback the two auxiliary outputs stand in for ring and carrier.
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps

module ulms_top
  import ulms_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic [ULMS_AW-1:0] addr,
  input  wire logic [7:0]         wr_data,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  output logic      [7:0]         rd_data,
  input  wire ulms_line_t         line_in,
  input  wire ulms_modem_t        modem_pin,
  output logic                    irq,
  output logic                    loop_aux_out_one,
  output logic                    loop_aux_out_two
);

  ulms_modem_t           pin_s1_q;
  ulms_modem_t           pin_s2_q;
  ulms_modem_t           prev_q;
  ulms_modem_t           modem_eff;
  ulms_modem_t           chg;
  logic                  ri_rise;
  logic [1:0]            prime_q;
  logic                  primed;
  ulms_line_t            lsr_q;
  ulms_msr_t             msr_q;
  ulms_ctrl_t            ctrl_q;
  logic [ULMS_EV_W-1:0]  ist_q;
  logic [ULMS_EV_W-1:0]  imsk_q;
  logic [ULMS_EV_W-1:0]  ev;
  logic [ULMS_EV_W-1:0]  ist_clr;
  logic                  irq_q;
  logic [7:0]            rd_data_q;
  logic                  msr_rd;
  logic                  err_now;
  logic                  err_was;

  assign primed           = (prime_q == ULMS_PRIME_FULL);
  assign msr_rd           = rd_en && (addr == ULMS_OFS_MSR);
  assign rd_data          = rd_data_q;
  assign irq              = irq_q;
  assign loop_aux_out_one = ctrl_q.loop_aux_out_one;
  assign loop_aux_out_two = ctrl_q.loop_aux_out_two;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Two-stage synchroniser on the modem pins.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= modem_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Loopback replaces ring and carrier with the auxiliary outputs.
  always_comb
  begin
    modem_eff = pin_s2_q;
    if (ctrl_q.loop_en)
    begin
      modem_eff.ri  = ctrl_q.loop_aux_out_one;
      modem_eff.dcd = ctrl_q.loop_aux_out_two;
    end
  end

  // Change detection starts once the sample pipeline holds real levels.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prime_q <= '0;
      prev_q  <= '0;
    end
    else
    begin
      prev_q <= modem_eff;
      if (!primed)
      begin
        prime_q <= prime_q + ULMS_PRIME_STEP;
      end
    end
  end

  always_comb
  begin
    chg     = primed ? (modem_eff ^ prev_q) : '0;
    ri_rise = primed && modem_eff.ri && !prev_q.ri;
  end

  // Change flags: a new change wins over the clearing read.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      msr_q <= '0;
    end
    else
    begin
      msr_q.cts_chg <= chg.cts || (msr_q.cts_chg && !msr_rd);
      msr_q.dsr_chg <= chg.dsr || (msr_q.dsr_chg && !msr_rd);
      msr_q.ri_rise <= ri_rise || (msr_q.ri_rise && !msr_rd);
      msr_q.dcd_chg <= chg.dcd || (msr_q.dcd_chg && !msr_rd);
      msr_q.cts_lvl <= modem_eff.cts;
      msr_q.dsr_lvl <= modem_eff.dsr;
      msr_q.ri_lvl  <= modem_eff.ri;
      msr_q.dcd_lvl <= modem_eff.dcd;
    end
  end

  // Line status follows the receiver and transmitter conditions.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lsr_q <= '0;
    end
    else
    begin
      lsr_q.data_avail <= line_in.data_avail;
      lsr_q.overrun    <= line_in.overrun;
      lsr_q.par_err    <= line_in.par_err;
      lsr_q.frm_err    <= line_in.frm_err;
      lsr_q.brk        <= line_in.brk;
      lsr_q.thr_empty  <= line_in.thr_empty;
      lsr_q.tsr_empty  <= line_in.tsr_empty;
      lsr_q.fifo_err   <= line_in.fifo_err;
    end
  end

  // Control register with the loopback and auxiliary output bits.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= '0;
    end
    else if (wr_en && (addr == ULMS_OFS_CTRL))
    begin
      ctrl_q                  <= '0;
      ctrl_q.loop_en          <= wr_data[4];
      ctrl_q.loop_aux_out_two <= wr_data[3];
      ctrl_q.loop_aux_out_one <= wr_data[2];
    end
  end

  // Interrupt events, sticky status, mask and level output.
  always_comb
  begin
    err_now = line_in.overrun || line_in.par_err || line_in.frm_err || line_in.brk;
    err_was = lsr_q.overrun || lsr_q.par_err || lsr_q.frm_err || lsr_q.brk;
    ev                  = '0;
    ev[ULMS_EV_MODEM]   = (|chg) || ri_rise;
    ev[ULMS_EV_LINEERR] = err_now && !err_was;
    ev[ULMS_EV_RXAVAIL] = line_in.data_avail && !lsr_q.data_avail;
    ev[ULMS_EV_TXEMPTY] = line_in.thr_empty && !lsr_q.thr_empty;
    ist_clr = (wr_en && (addr == ULMS_OFS_IST)) ? wr_data[ULMS_EV_W-1:0] : '0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ist_q <= ULMS_RST_NIB;
    end
    else
    begin
      ist_q <= ev | (ist_q & ~ist_clr);
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      imsk_q <= ULMS_RST_NIB;
    end
    else if (wr_en && (addr == ULMS_OFS_IMSK))
    begin
      imsk_q <= wr_data[ULMS_EV_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(ist_q & imsk_q);
    end
  end

  // Read data stands in the cycle after the read strobe only.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data_q <= ULMS_RST_BYTE;
    end
    else if (rd_en)
    begin
      unique case (addr)
        ULMS_OFS_CTRL: rd_data_q <= ctrl_q;
        ULMS_OFS_LSR:  rd_data_q <= lsr_q;
        ULMS_OFS_MSR:  rd_data_q <= msr_q;
        ULMS_OFS_IST:  rd_data_q <= {4'h0, ist_q};
        ULMS_OFS_IMSK: rd_data_q <= {4'h0, imsk_q};
        default:       rd_data_q <= ULMS_RST_BYTE;
      endcase
    end
    else
    begin
      rd_data_q <= ULMS_RST_BYTE;
    end
  end

  // Checks on the line status path.
  a_lsr_read_data: assert property (
    rd_en && (addr == ULMS_OFS_LSR) |=> rd_data[0] == $past(line_in.data_avail, 2))
    else $error("Line bit 0 does not follow the receive data flag.");

  a_lsr_overrun: assert property (
    line_in.overrun ##1 line_in.overrun |-> lsr_q.overrun)
    else $error("Overrun flag missing.");

  a_lsr_par_frm: assert property (
    ##1 (lsr_q.par_err == $past(line_in.par_err)) && (lsr_q.frm_err == $past(line_in.frm_err)))
    else $error("Parity or framing flag wrong.");

  a_lsr_break: assert property (
    ##1 (lsr_q.brk == $past(line_in.brk)))
    else $error("Break flag not reported.");

  a_lsr_tx_empty: assert property (
    !line_in.thr_empty |=> !lsr_q.thr_empty)
    else $error("Holding empty flag set while full.");

  a_lsr_tx_done: assert property (
    $fell(line_in.tsr_empty) |=> !lsr_q.tsr_empty)
    else $error("Shift empty flag stays high while shifting.");

  a_lsr_fifo_err: assert property (
    line_in.fifo_err |=> lsr_q.fifo_err)
    else $error("Receive FIFO error bit not set.");

  a_avail_follow: assert property (
    ##1 (lsr_q.data_avail == $past(line_in.data_avail)))
    else $error("Data available flag does not follow the receiver.");

  a_overrun_clr: assert property (
    !line_in.overrun |=> !lsr_q.overrun)
    else $error("Overrun flag set without an overrun.");

  a_thr_empty_set: assert property (
    line_in.thr_empty |=> lsr_q.thr_empty)
    else $error("Holding empty flag low while empty.");

  a_tsr_empty_set: assert property (
    line_in.tsr_empty |=> lsr_q.tsr_empty)
    else $error("Shift empty flag low while empty.");

  a_fifo_err_clr: assert property (
    !line_in.fifo_err |=> !lsr_q.fifo_err)
    else $error("Receive FIFO error bit set without an error.");

  // Checks on the modem status path, interrupt status and output, read data and auxiliary outputs.
  a_msr_cts_chg: assert property (
    primed && (modem_eff.cts != prev_q.cts) |=> msr_q.cts_chg)
    else $error("Clear-to-send change not flagged.");

  a_msr_dsr_chg: assert property (
    primed && (modem_eff.dsr != prev_q.dsr) |=> msr_q.dsr_chg)
    else $error("Data-set-ready change not flagged.");

  a_msr_ri_rise: assert property (
    !msr_q.ri_rise && !(primed && modem_eff.ri && !prev_q.ri) |=> !msr_q.ri_rise)
    else $error("Ring flag set without a rising edge.");

  a_msr_dcd_chg: assert property (
    primed && (modem_eff.dcd != prev_q.dcd) |=> msr_q.dcd_chg)
    else $error("Carrier-detect change not flagged.");

  a_msr_read_clr: assert property (
    msr_rd && !(|chg) && !ri_rise |=> msr_q[3:0] == 4'h0)
    else $error("Modem change flags not cleared by read.");

  a_msr_cts_lvl: assert property (
    ##3 (msr_q.cts_lvl == $past(modem_pin.cts, 3)) && (msr_q.dsr_lvl == $past(modem_pin.dsr, 3)))
    else $error("Clear-to-send or data-set-ready level wrong.");

  a_msr_ri_lvl: assert property (
    !ctrl_q.loop_en ##1 !ctrl_q.loop_en |-> msr_q.ri_lvl == $past(pin_s2_q.ri))
    else $error("Ring level wrong.");

  a_msr_dcd_lvl: assert property (
    !ctrl_q.loop_en ##1 !ctrl_q.loop_en |-> msr_q.dcd_lvl == $past(pin_s2_q.dcd))
    else $error("Carrier level wrong.");

  a_msr_loopback: assert property (
    ctrl_q.loop_en |=> (msr_q.ri_lvl == $past(ctrl_q.loop_aux_out_one))
                       && (msr_q.dcd_lvl == $past(ctrl_q.loop_aux_out_two)))
    else $error("Loopback levels not routed.");

  a_msr_set_wins: assert property (
    msr_rd && primed && (modem_eff.cts != prev_q.cts) |=> msr_q.cts_chg)
    else $error("Change lost under a clearing read.");

  a_irq_level: assert property (
    ##1 irq == $past(|(ist_q & imsk_q)))
    else $error("Interrupt output does not match masked status.");

  a_msr_ri_set: assert property (
    primed && modem_eff.ri && !prev_q.ri |=> msr_q.ri_rise)
    else $error("Rising ring indicator not flagged.");

  a_msr_cts_hold: assert property (
    !msr_rd && msr_q.cts_chg |=> msr_q.cts_chg)
    else $error("Clear-to-send flag lost without a read.");

  a_msr_dcd_hold: assert property (
    !msr_rd && msr_q.dcd_chg |=> msr_q.dcd_chg)
    else $error("Carrier-detect flag lost without a read.");

  a_sync_second: assert property (
    ##1 (pin_s2_q == $past(pin_s1_q)))
    else $error("Second synchroniser stage does not follow the first.");

  a_rd_idle_zero: assert property (
    !rd_en |=> rd_data == ULMS_RST_BYTE)
    else $error("Read data not zero outside a read.");

  a_rd_msr_data: assert property (
    msr_rd |=> rd_data == $past(msr_q))
    else $error("Modem status read returns wrong data.");

  a_irq_status_set: assert property (
    ev[ULMS_EV_MODEM] |=> ist_q[ULMS_EV_MODEM])
    else $error("Modem event not held in interrupt status.");

  a_ist_clear: assert property (
    wr_en && (addr == ULMS_OFS_IST) && wr_data[ULMS_EV_MODEM] && !ev[ULMS_EV_MODEM]
    |=> !ist_q[ULMS_EV_MODEM])
    else $error("Interrupt status bit not cleared by a written one.");

  a_aux_follow: assert property (
    wr_en && (addr == ULMS_OFS_CTRL) |=> (loop_aux_out_one == $past(wr_data[2]))
                                       && (loop_aux_out_two == $past(wr_data[3])))
    else $error("Auxiliary outputs do not follow the control write.");

endmodule : ulms_top

// file: rtl/ulms_pkg.sv
// Package with offsets, field positions and carrier types for the line and modem status block.
package ulms_pkg;

  localparam int         ULMS_AW         = 8;
  localparam logic [7:0] ULMS_OFS_CTRL   = 8'h04;
  localparam logic [7:0] ULMS_OFS_LSR    = 8'h05;
  localparam logic [7:0] ULMS_OFS_MSR    = 8'h06;
  localparam logic [7:0] ULMS_OFS_IST    = 8'h08;
  localparam logic [7:0] ULMS_OFS_IMSK   = 8'h09;
  localparam logic [7:0] ULMS_RST_BYTE   = 8'h00;
  localparam logic [3:0] ULMS_RST_NIB    = 4'h0;
  localparam logic [1:0] ULMS_PRIME_FULL = 2'h3;
  localparam logic [1:0] ULMS_PRIME_STEP = 2'h1;
  localparam int         ULMS_EV_MODEM   = 0;
  localparam int         ULMS_EV_LINEERR = 1;
  localparam int         ULMS_EV_RXAVAIL = 2;
  localparam int         ULMS_EV_TXEMPTY = 3;
  localparam int         ULMS_EV_W       = 4;

  typedef struct packed {
    logic fifo_err;
    logic tsr_empty;
    logic thr_empty;
    logic brk;
    logic frm_err;
    logic par_err;
    logic overrun;
    logic data_avail;
  } ulms_line_t;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } ulms_modem_t;

  typedef struct packed {
    logic dcd_lvl;
    logic ri_lvl;
    logic dsr_lvl;
    logic cts_lvl;
    logic dcd_chg;
    logic ri_rise;
    logic dsr_chg;
    logic cts_chg;
  } ulms_msr_t;

  typedef struct packed {
    logic [2:0] rsv_hi;
    logic       loop_en;
    logic       loop_aux_out_two;
    logic       loop_aux_out_one;
    logic [1:0] rsv_lo;
  } ulms_ctrl_t;

endpackage : ulms_pkg

// file: tb/ulms_remote.sv
// Model of the remote equipment that drives the modem handshake pins.
`timescale 1ns/10ps

module ulms_remote
  import ulms_pkg::*;
#(
  parameter time SKEW = 3ns
)
(
  input  wire logic [3:0] want,
  output ulms_modem_t     pins
);

  // Pins move off the clock edges, as an unrelated remote device would.
  assign #(SKEW) pins = ulms_modem_t'(want);

endmodule : ulms_remote

// file: tb/uart_line_modem_status_tb.sv
// Self-checking testbench for the line and modem status block.
`timescale 1ns/10ps

module uart_line_modem_status_tb
  import ulms_pkg::*;
;
  logic        clk;
  logic        nrst;
  logic [7:0]  addr;
  logic [7:0]  wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rd_data;
  ulms_line_t  line_in;
  ulms_modem_t modem_pin;
  logic [3:0]  want;
  logic        irq;
  logic        aux_one;
  logic        aux_two;
  int          failures;
  int          compares;

  ulms_top dut (
    .clk              (clk),
    .nrst             (nrst),
    .addr             (addr),
    .wr_data          (wr_data),
    .wr_en            (wr_en),
    .rd_en            (rd_en),
    .rd_data          (rd_data),
    .line_in          (line_in),
    .modem_pin        (modem_pin),
    .irq              (irq),
    .loop_aux_out_one (aux_one),
    .loop_aux_out_two (aux_two)
  );

  ulms_remote remote (
    .want (want),
    .pins (modem_pin)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask : rd

  task automatic t_reset();
    rd(ULMS_OFS_LSR, 8'h00);
    rd(ULMS_OFS_MSR, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("Test reset values done");
  endtask : t_reset

  task automatic t_line();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      line_in <= ulms_line_t'(8'h01 << i);
      cyc(2);
      rd(ULMS_OFS_LSR, 8'h01 << i);
    end
    wr(ULMS_OFS_LSR, 8'hFF);
    rd(ULMS_OFS_LSR, 8'h80);
    @(posedge clk);
    line_in <= ulms_line_t'(8'h00);
    cyc(2);
    rd(ULMS_OFS_LSR, 8'h00);
    rd(8'h0F, 8'h00);
    rd(ULMS_OFS_IST, 8'h0E);
    wr(ULMS_OFS_IST, 8'h0A);
    rd(ULMS_OFS_IST, 8'h04);
    $display("Test line status done");
  endtask : t_line

  task automatic t_modem();
    for (int i = 0; i < 4; i++)
    begin
      want[i] = 1'b1;
      cyc(5);
      rd(ULMS_OFS_MSR, (8'h10 << i) | (8'h01 << i));
      want[i] = 1'b0;
      cyc(5);
      rd(ULMS_OFS_MSR, (i == 2) ? 8'h00 : (8'h01 << i));
    end
    $display("Test modem status done");
  endtask : t_modem

  task automatic t_loop();
    wr(ULMS_OFS_CTRL, 8'h1C);
    cyc(6);
    chk({6'h00, aux_two, aux_one}, 8'h03);
    rd(ULMS_OFS_MSR, 8'hCC);
    wr(ULMS_OFS_CTRL, 8'h00);
    cyc(6);
    rd(ULMS_OFS_MSR, 8'h08);
    rd(ULMS_OFS_CTRL, 8'h00);
    $display("Test loopback done");
  endtask : t_loop

  task automatic t_irq();
    wr(ULMS_OFS_IST, 8'h0F);
    wr(ULMS_OFS_IMSK, 8'h01);
    chk({7'h00, irq}, 8'h00);
    rd(ULMS_OFS_IMSK, 8'h01);
    want[0] = 1'b1;
    cyc(6);
    chk({7'h00, irq}, 8'h01);
    rd(ULMS_OFS_IST, 8'h01);
    rd(ULMS_OFS_MSR, 8'h11);
    wr(ULMS_OFS_IST, 8'h01);
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    rd(ULMS_OFS_MSR, 8'h10);
    $display("Test interrupt done");
  endtask : t_irq

  task automatic t_race();
    want[0] = 1'b0;
    cyc(1);
    rd(ULMS_OFS_MSR, 8'h10);
    rd(ULMS_OFS_MSR, 8'h01);
    $display("Test change against read done");
  endtask : t_race

  initial
  begin
    failures = 0;
    compares = 0;
    nrst     = 1'b0;
    addr     = 8'h00;
    wr_data  = 8'h00;
    wr_en    = 1'b0;
    rd_en    = 1'b0;
    line_in  = ulms_line_t'(8'h00);
    want     = 4'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    cyc(4);
    t_reset();
    t_line();
    t_modem();
    t_loop();
    t_irq();
    t_race();
    give_verdict();
  end

  initial
  begin
    #100us;
    failures++;
    give_verdict();
  end

endmodule : uart_line_modem_status_tb
